/* logic/sct_regs.sv */
// spur cancel and trim register bank behind an axi4-lite slave
// assumes one clock, synchronous active-low reset, master per axi4-lite
module sct_regs (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [sct_pkg::addr_width-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [sct_pkg::addr_width-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // cmos output path
    input wire logic divider_in,
    input wire logic divider_out,
    output logic cmos_out,
    // settings to the dac and spur cancellers
    output logic [9:0] dac_current,
    output logic cancel_chan_a_enable,
    output logic chan_a_gain_x2,
    output logic [3:0] chan_a_harmonic,
    output logic [7:0] chan_a_magnitude,
    output logic [8:0] chan_a_phase,
    output logic cancel_chan_b_enable,
    output logic chan_b_gain_x2,
    output logic [3:0] chan_b_harmonic,
    output logic [7:0] chan_b_magnitude,
    output logic [8:0] chan_b_phase
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] dac_current_trim_low;
    logic [7:0] dac_current_trim_high;
    logic [7:0] cancel_chan_a_control;
    logic [7:0] cancel_chan_a_magnitude;
    logic [7:0] cancel_chan_a_phase_low;
    logic [7:0] cancel_chan_a_phase_high;
    logic [7:0] cancel_chan_b_control;
    logic [7:0] cancel_chan_b_magnitude;
    logic [7:0] cancel_chan_b_phase_low;
    logic [7:0] cancel_chan_b_phase_high;
    logic [7:0] output_driver_source;

    // word index from byte address; low two bits ignored
    function automatic logic [11:0] word_index(input logic [sct_pkg::addr_width-1:0] addr);
        return addr[sct_pkg::addr_width-1:2];
    endfunction : word_index

    // writable mask of a register, zero where unmapped
    function automatic logic [7:0] reg_mask(input logic [11:0] idx);
        unique case (idx)
            sct_pkg::idx_dac_trim_low,
            sct_pkg::idx_chan_a_magnitude,
            sct_pkg::idx_chan_a_phase_low,
            sct_pkg::idx_chan_b_magnitude,
            sct_pkg::idx_chan_b_phase_low: return 8'hFF;
            sct_pkg::idx_dac_trim_high: return sct_pkg::trim_high_mask;
            sct_pkg::idx_chan_a_control,
            sct_pkg::idx_chan_b_control: return sct_pkg::control_mask;
            sct_pkg::idx_chan_a_phase_high,
            sct_pkg::idx_chan_b_phase_high: return sct_pkg::phase_high_mask;
            sct_pkg::idx_output_source: return sct_pkg::source_mask;
            default: return 8'h00;
        endcase
    endfunction : reg_mask

    function automatic logic is_mapped(input logic [11:0] idx);
        return (idx == sct_pkg::idx_dac_trim_low) || (idx == sct_pkg::idx_dac_trim_high)
            || (idx == sct_pkg::idx_chan_a_control) || (idx == sct_pkg::idx_chan_a_magnitude)
            || (idx == sct_pkg::idx_chan_a_phase_low) || (idx == sct_pkg::idx_chan_a_phase_high)
            || (idx == sct_pkg::idx_chan_b_control) || (idx == sct_pkg::idx_chan_b_magnitude)
            || (idx == sct_pkg::idx_chan_b_phase_low) || (idx == sct_pkg::idx_chan_b_phase_high)
            || (idx == sct_pkg::idx_output_source);
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data latched in either order
    logic aw_held;
    logic w_held;
    logic [11:0] aw_idx;
    logic [7:0] w_byte;
    logic w_lane0;
    logic do_write;
    logic [7:0] wmask;
    logic [7:0] next_byte;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held;
    assign wmask = reg_mask(aw_idx);
    // reserved bits never store, so they read zero
    assign next_byte = w_byte & wmask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_idx <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx <= word_index(s_axi_awaddr);
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sct_pkg::resp_okay;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_idx) ? sct_pkg::resp_okay : sct_pkg::resp_slverr;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register storage; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dac_current_trim_low <= sct_pkg::reset_byte;
            dac_current_trim_high <= sct_pkg::reset_byte;
            cancel_chan_a_control <= sct_pkg::reset_byte;
            cancel_chan_a_magnitude <= sct_pkg::reset_byte;
            cancel_chan_a_phase_low <= sct_pkg::reset_byte;
            cancel_chan_a_phase_high <= sct_pkg::reset_byte;
            cancel_chan_b_control <= sct_pkg::reset_byte;
            cancel_chan_b_magnitude <= sct_pkg::reset_byte;
            cancel_chan_b_phase_low <= sct_pkg::reset_byte;
            cancel_chan_b_phase_high <= sct_pkg::reset_byte;
            output_driver_source <= sct_pkg::reset_byte;
        end else if (do_write && w_lane0) begin
            unique case (aw_idx)
                sct_pkg::idx_dac_trim_low: dac_current_trim_low <= next_byte;
                sct_pkg::idx_dac_trim_high: dac_current_trim_high <= next_byte;
                sct_pkg::idx_chan_a_control: cancel_chan_a_control <= next_byte;
                sct_pkg::idx_chan_a_magnitude: cancel_chan_a_magnitude <= next_byte;
                sct_pkg::idx_chan_a_phase_low: cancel_chan_a_phase_low <= next_byte;
                sct_pkg::idx_chan_a_phase_high: cancel_chan_a_phase_high <= next_byte;
                sct_pkg::idx_chan_b_control: cancel_chan_b_control <= next_byte;
                sct_pkg::idx_chan_b_magnitude: cancel_chan_b_magnitude <= next_byte;
                sct_pkg::idx_chan_b_phase_low: cancel_chan_b_phase_low <= next_byte;
                sct_pkg::idx_chan_b_phase_high: cancel_chan_b_phase_high <= next_byte;
                sct_pkg::idx_output_source: output_driver_source <= next_byte;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel: one cycle from address to data
    logic [11:0] r_idx;
    logic [7:0] read_byte;

    assign s_axi_arready = !s_axi_rvalid;
    assign r_idx = word_index(s_axi_araddr);

    always_comb begin
        unique case (r_idx)
            sct_pkg::idx_dac_trim_low: read_byte = dac_current_trim_low;
            sct_pkg::idx_dac_trim_high: read_byte = dac_current_trim_high;
            sct_pkg::idx_chan_a_control: read_byte = cancel_chan_a_control;
            sct_pkg::idx_chan_a_magnitude: read_byte = cancel_chan_a_magnitude;
            sct_pkg::idx_chan_a_phase_low: read_byte = cancel_chan_a_phase_low;
            sct_pkg::idx_chan_a_phase_high: read_byte = cancel_chan_a_phase_high;
            sct_pkg::idx_chan_b_control: read_byte = cancel_chan_b_control;
            sct_pkg::idx_chan_b_magnitude: read_byte = cancel_chan_b_magnitude;
            sct_pkg::idx_chan_b_phase_low: read_byte = cancel_chan_b_phase_low;
            sct_pkg::idx_chan_b_phase_high: read_byte = cancel_chan_b_phase_high;
            sct_pkg::idx_output_source: read_byte = output_driver_source;
            default: read_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sct_pkg::resp_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, read_byte};
            s_axi_rresp <= is_mapped(r_idx) ? sct_pkg::resp_okay : sct_pkg::resp_slverr;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings out
    // the cmos path is a plain mux; glitches on a source change are accepted
    assign cmos_out = output_driver_source[sct_pkg::pos_source] ? divider_out : divider_in;
    assign dac_current = {dac_current_trim_high[1:0], dac_current_trim_low};
    assign cancel_chan_a_enable = cancel_chan_a_control[sct_pkg::pos_enable];
    assign chan_a_gain_x2 = cancel_chan_a_control[sct_pkg::pos_gain_x2];
    // harmonic 0 is outside the 1..15 range; passed on as written
    assign chan_a_harmonic = cancel_chan_a_control[sct_pkg::pos_harmonic +: sct_pkg::harmonic_width];
    assign chan_a_magnitude = cancel_chan_a_magnitude;
    assign chan_a_phase = {cancel_chan_a_phase_high[0], cancel_chan_a_phase_low};
    assign cancel_chan_b_enable = cancel_chan_b_control[sct_pkg::pos_enable];
    assign chan_b_gain_x2 = cancel_chan_b_control[sct_pkg::pos_gain_x2];
    assign chan_b_harmonic = cancel_chan_b_control[sct_pkg::pos_harmonic +: sct_pkg::harmonic_width];
    assign chan_b_magnitude = cancel_chan_b_magnitude;
    assign chan_b_phase = {cancel_chan_b_phase_high[0], cancel_chan_b_phase_low};

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_ctl_a;
        do_write && w_lane0 && aw_idx == sct_pkg::idx_chan_a_control;
    endsequence

    a_src_mux_path: assert property (cmos_out == (output_driver_source[0] ? divider_out : divider_in))
        else $error("cmos output source wrong");
    a_trim_low_store: assert property (do_write && w_lane0 && aw_idx == sct_pkg::idx_dac_trim_low
        |=> dac_current[7:0] == $past(w_byte))
        else $error("trim low not stored");
    a_trim_high_store: assert property (do_write && w_lane0 && aw_idx == sct_pkg::idx_dac_trim_high
        |=> dac_current[9:8] == $past(w_byte[1:0]))
        else $error("trim high not stored");
    a_chan_a_enable: assert property (s_write_ctl_a |=> cancel_chan_a_enable == $past(w_byte[7]))
        else $error("channel a enable wrong");
    a_gain_doubling: assert property (s_write_ctl_a |=> chan_a_gain_x2 == $past(w_byte[6]))
        else $error("channel a gain bit wrong");
    a_chan_a_harmonic: assert property (s_write_ctl_a |=> chan_a_harmonic == $past(w_byte[3:0]))
        else $error("channel a harmonic wrong");
    a_chan_a_magnitude: assert property (do_write && w_lane0 && aw_idx == sct_pkg::idx_chan_a_magnitude
        |=> chan_a_magnitude == $past(w_byte))
        else $error("channel a magnitude wrong");
    a_chan_a_phase: assert property (do_write && w_lane0 && aw_idx == sct_pkg::idx_chan_a_phase_high
        |=> chan_a_phase[8] == $past(w_byte[0]))
        else $error("channel a phase bit 8 wrong");
    a_chan_b_enable: assert property (do_write && w_lane0 && aw_idx == sct_pkg::idx_chan_b_control
        |=> cancel_chan_b_enable == $past(w_byte[7]) && chan_b_harmonic == $past(w_byte[3:0]))
        else $error("channel b control wrong");
    a_chan_b_phase: assert property (do_write && w_lane0 && aw_idx == sct_pkg::idx_chan_b_phase_low
        |=> chan_b_phase[7:0] == $past(w_byte) && chan_b_magnitude == $past(chan_b_magnitude))
        else $error("channel b phase low wrong");
    a_chan_b_magnitude: assert property (do_write && w_lane0 && aw_idx == sct_pkg::idx_chan_b_magnitude
        |=> chan_b_magnitude == $past(w_byte))
        else $error("channel b magnitude wrong");
    a_chan_b_harmonic: assert property (chan_b_harmonic == cancel_chan_b_control[3:0])
        else $error("channel b harmonic wrong");
    a_reserved_zero: assert property (cancel_chan_a_control[5:4] == 2'h0
        && cancel_chan_b_control[5:4] == 2'h0)
        else $error("reserved control bits set");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");

endmodule : sct_regs

/* common/sct_pkg.sv */
// constants for the spur cancel and trim register bank
// assumes an axi4-lite slave with 32-bit data, one register per word
package sct_pkg;
    // printed offsets are not multiples of four: they are register indices
    localparam logic [11:0] idx_dac_trim_low = 12'h40B;
    localparam logic [11:0] idx_dac_trim_high = 12'h40C;
    localparam logic [11:0] idx_chan_a_control = 12'h500;
    localparam logic [11:0] idx_chan_a_magnitude = 12'h501;
    localparam logic [11:0] idx_chan_a_phase_low = 12'h503;
    localparam logic [11:0] idx_chan_a_phase_high = 12'h504;
    localparam logic [11:0] idx_chan_b_control = 12'h505;
    localparam logic [11:0] idx_chan_b_magnitude = 12'h506;
    localparam logic [11:0] idx_chan_b_phase_low = 12'h508;
    localparam logic [11:0] idx_chan_b_phase_high = 12'h509;
    localparam logic [11:0] idx_output_source = 12'h201;
    localparam int addr_width = 14;
    // control register fields, other write masks, reset value and responses
    localparam int pos_enable = 7;
    localparam int pos_gain_x2 = 6;
    localparam int pos_harmonic = 0;
    localparam int harmonic_width = 4;
    localparam logic [7:0] control_mask = 8'hCF;
    localparam logic [7:0] trim_high_mask = 8'h03;
    localparam logic [7:0] phase_high_mask = 8'h01;
    localparam logic [7:0] source_mask = 8'h01;
    localparam int pos_source = 0;
    localparam logic [7:0] reset_byte = 8'h00;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage : sct_pkg

/* sim/sct_tb.sv */
// self-checking bench for the spur cancel and trim register bank
// assumes sct_pkg compiled first; axi4-lite master and reference model live here
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn;
    logic [13:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic divider_in, divider_out, cmos_out;
    logic [9:0] dac_current;
    logic a_en, a_x2, b_en, b_x2;
    logic [3:0] a_harm, b_harm;
    logic [7:0] a_mag, b_mag;
    logic [8:0] a_ph, b_ph;
    int n_mismatch = 0;
    int checked = 0;
    logic [7:0] model [0:4095];
    // mapped indices; the source register index is a local choice of the design
    int regs [11] = '{sct_pkg::idx_dac_trim_low, sct_pkg::idx_dac_trim_high, sct_pkg::idx_chan_a_control,
        sct_pkg::idx_chan_a_magnitude, sct_pkg::idx_chan_a_phase_low, sct_pkg::idx_chan_a_phase_high,
        sct_pkg::idx_chan_b_control, sct_pkg::idx_chan_b_magnitude, sct_pkg::idx_chan_b_phase_low,
        sct_pkg::idx_chan_b_phase_high, sct_pkg::idx_output_source};
    int holes [3] = '{12'h40A, 12'h502, 12'h507};
    sct_regs dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .divider_in(divider_in), .divider_out(divider_out), .cmos_out(cmos_out), .dac_current(dac_current),
        .cancel_chan_a_enable(a_en), .chan_a_gain_x2(a_x2), .chan_a_harmonic(a_harm),
        .chan_a_magnitude(a_mag), .chan_a_phase(a_ph),
        .cancel_chan_b_enable(b_en), .chan_b_gain_x2(b_x2), .chan_b_harmonic(b_harm),
        .chan_b_magnitude(b_mag), .chan_b_phase(b_ph));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        #(100 * 4000);
        n_mismatch++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("errors %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp
    function automatic logic [7:0] mask_of(input int i);
        case (i)
            sct_pkg::idx_chan_a_control, sct_pkg::idx_chan_b_control: return sct_pkg::control_mask;
            sct_pkg::idx_dac_trim_high: return sct_pkg::trim_high_mask;
            sct_pkg::idx_chan_a_phase_high, sct_pkg::idx_chan_b_phase_high: return sct_pkg::phase_high_mask;
            sct_pkg::idx_output_source: return sct_pkg::source_mask;
            default: return 8'hFF;
        endcase
    endfunction : mask_of
    ////////////////////////////////////////////////////////////////////////////////
    // both channels offered together, each dropped on its own handshake edge
    task automatic axi_write(input int idx, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h1;
        @(posedge aclk);
        awaddr <= 14'(idx * 4);
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 100);
        if (bvalid) r = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input int idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        d = 'x;
        r = 2'h1;
        @(posedge aclk);
        araddr <= 14'(idx * 4);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 100);
        if (rvalid) begin
            d = rdata;
            r = rresp;
        end
        rready <= 1'b0;
    endtask : axi_read
    ////////////////////////////////////////////////////////////////////////////////
    task automatic read_all();
        logic [31:0] d;
        logic [1:0] r;
        foreach (regs[k]) begin
            axi_read(regs[k], d, r);
            cmp(d, {24'h0, model[regs[k]]}, "readback");
            cmp(r, sct_pkg::resp_okay, "read resp");
        end
    endtask : read_all
    task automatic check_outputs();
        logic [7:0] ac, bc;
        logic [9:0] dac_exp;
        logic [8:0] aph_exp, bph_exp;
        ac = model[sct_pkg::idx_chan_a_control];
        bc = model[sct_pkg::idx_chan_b_control];
        dac_exp = {model[sct_pkg::idx_dac_trim_high][1:0], model[sct_pkg::idx_dac_trim_low]};
        aph_exp = {model[sct_pkg::idx_chan_a_phase_high][0], model[sct_pkg::idx_chan_a_phase_low]};
        bph_exp = {model[sct_pkg::idx_chan_b_phase_high][0], model[sct_pkg::idx_chan_b_phase_low]};
        cmp(dac_current, dac_exp, "dac");
        cmp({a_en, a_x2, a_harm}, {ac[7], ac[6], ac[3:0]}, "chan a control");
        cmp({b_en, b_x2, b_harm}, {bc[7], bc[6], bc[3:0]}, "chan b control");
        cmp(a_mag, model[sct_pkg::idx_chan_a_magnitude], "a mag");
        cmp(b_mag, model[sct_pkg::idx_chan_b_magnitude], "b mag");
        cmp(a_ph, aph_exp, "a phase");
        cmp(b_ph, bph_exp, "b phase");
        for (int k = 0; k < 4; k++) begin
            @(posedge aclk);
            divider_in <= k[0];
            divider_out <= k[1];
            @(negedge aclk);
            cmp(cmos_out, model[sct_pkg::idx_output_source][0] ? k[1] : k[0], "cmos source");
        end
    endtask : check_outputs
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, divider_in, divider_out} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        foreach (model[i]) model[i] = sct_pkg::reset_byte;
        void'($urandom(32'h394a4960));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        read_all();
        check_outputs();
        // random, all ones, random: all ones exposes any stray reserved bit
        for (int p = 0; p < 3; p++) begin
            foreach (regs[k]) begin
                d = (p == 1) ? 32'hFFFFFFFF : $urandom;
                axi_write(regs[k], d, 4'hF, r);
                cmp(r, sct_pkg::resp_okay, "write resp");
                model[regs[k]] = d[7:0] & mask_of(regs[k]);
                check_outputs();
            end
            read_all();
        end
        // low strobe clear: answered but nothing stored
        foreach (regs[k]) begin
            axi_write(regs[k], ~{24'h0, model[regs[k]]}, 4'hE, r);
            cmp(r, sct_pkg::resp_okay, "strobe resp");
        end
        read_all();
        foreach (holes[k]) begin
            axi_write(holes[k], 32'hFFFFFFFF, 4'hF, r);
            cmp(r, sct_pkg::resp_slverr, "unmapped write");
            axi_read(holes[k], d, r);
            cmp(r, sct_pkg::resp_slverr, "unmapped read resp");
            cmp(d, 32'h0, "unmapped read data");
        end
        check_outputs();
        // second reset in mid-run must clear every setting
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (model[i]) model[i] = sct_pkg::reset_byte;
        read_all();
        check_outputs();
        conclude();
    end
endmodule : tb
